// file: src/nvsram_ctl_pkg.sv
// constants for the host-side controller of a nonvolatile-shadowed 32k x 8 static memory
// assumes a 250 MHz single clock and an asynchronous memory on plain pins
package nvsram_ctl_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEQ_LEN = 6;
  localparam int unsigned SEQ_CMP_W = 14;
  localparam logic [13:0] SEQ_A1 = 14'h0e38;
  localparam logic [13:0] SEQ_A2 = 14'h31c7;
  localparam logic [13:0] SEQ_A3 = 14'h03e0;
  localparam logic [13:0] SEQ_A4 = 14'h3c1f;
  localparam logic [13:0] SEQ_A5 = 14'h303f;
  localparam logic [13:0] SEQ_STORE = 14'h0fc0;
  localparam logic [13:0] SEQ_RECALL = 14'h0c63;
  // access phase lengths in ns
  localparam int unsigned ACCESS_NS = 48;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  // wait times, longest figures
  localparam int unsigned STORE_DURATION_MS = 10;
  localparam int unsigned STORE_CYC = STORE_DURATION_MS * 1000 * CLK_MHZ;
  localparam int unsigned RECALL_US = 20;
  localparam int unsigned RECALL_CYC = RECALL_US * CLK_MHZ;
  localparam int unsigned POWER_UP_RECALL_US = 550;
  localparam int unsigned POWER_UP_RECALL_CYC = POWER_UP_RECALL_US * CLK_MHZ;
  localparam int unsigned CNT_W = 22;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_STORE = 2'h2;
  localparam logic [1:0] CMD_RECALL = 2'h3;
endpackage : nvsram_ctl_pkg

// file: src/nvsram_host_ctl.sv
// host controller driving the nonvolatile static memory through its asynchronous pins
// assumes memory pins sampled synchronously to mclk_i; no other party drives the address
//
// Contract
// - address set on the same edge the write starts, steady until write ends
// - output enable kept high throughout writes
// - store: six chip-enable reads, 0e38 31c7 03e0 3c1f 303f 0fc0
// - recall: same five reads then 0c63
// - sequence uses reads, ended by chip enable, output enable high
// - data load held high at end of power-up recall
`timescale 1ns/1ps
`default_nettype none
module nvsram_host_ctl #(
  parameter int unsigned STORE_WAIT = nvsram_ctl_pkg::STORE_CYC,
  parameter int unsigned RECALL_WAIT = nvsram_ctl_pkg::RECALL_CYC,
  parameter int unsigned POWERUP_WAIT = nvsram_ctl_pkg::POWER_UP_RECALL_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // user command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_op_i,
  input wire logic [nvsram_ctl_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic [nvsram_ctl_pkg::DATA_W-1:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic [nvsram_ctl_pkg::DATA_W-1:0] rsp_rdata_o,
  // memory pins
  output logic [nvsram_ctl_pkg::ADDR_W-1:0] mem_addr_o,
  output logic chip_on_low_n_o,
  output logic output_on_low_n_o,
  output logic data_load_n_o,
  input wire logic [nvsram_ctl_pkg::DATA_W-1:0] data_lines_i,
  output logic [nvsram_ctl_pkg::DATA_W-1:0] data_lines_o,
  output logic data_lines_oe_n_o,
  input wire logic hardware_store_busy_n_i,
  output logic hardware_store_busy_n_o,
  output logic hardware_store_busy_oe_n_o,
  // status
  output logic nv_busy_o
);
  import nvsram_ctl_pkg::*;

  // refuse waits that the counter cannot hold
  if (STORE_WAIT < 1 || RECALL_WAIT < 1 || POWERUP_WAIT < 1 ||
      STORE_WAIT >= (1 << CNT_W) || RECALL_WAIT >= (1 << CNT_W) ||
      POWERUP_WAIT >= (1 << CNT_W)) begin : g_bad_wait
    $error("wait counts out of range");
  end

  typedef enum logic [2:0] {
    S_BOOT = 3'b000,
    S_IDLE = 3'b001,
    S_ACC = 3'b010,
    S_GAP = 3'b011,
    S_WAIT = 3'b100,
    S_HOLD = 3'b101
  } state_t;

  function automatic logic [13:0] seq_addr(input logic [2:0] idx, input logic is_store);
    unique case (idx)
      3'd0: seq_addr = SEQ_A1;
      3'd1: seq_addr = SEQ_A2;
      3'd2: seq_addr = SEQ_A3;
      3'd3: seq_addr = SEQ_A4;
      3'd4: seq_addr = SEQ_A5;
      default: seq_addr = is_store ? SEQ_STORE : SEQ_RECALL;
    endcase
  endfunction

  state_t state;
  logic [CNT_W-1:0] cnt;
  logic [2:0] seq_idx;
  logic is_write;
  logic is_seq;
  logic seq_store;
  logic next_acc;
  logic next_wr;
  logic next_seq;

  assign cmd_ready_o = (state == S_IDLE) && hardware_store_busy_n_i;
  assign nv_busy_o = (state == S_BOOT) || (state == S_WAIT) || (state == S_HOLD);
  assign hardware_store_busy_n_o = 1'b1;
  assign hardware_store_busy_oe_n_o = 1'b1;

  // sequencer: one access at a time, nonvolatile waits after a full sequence
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_BOOT;
      cnt <= '0;
      seq_idx <= 3'd0;
      is_write <= 1'b0;
      is_seq <= 1'b0;
      seq_store <= 1'b0;
    end else begin
      unique case (state)
        S_BOOT: begin
          if (cnt == CNT_W'(POWERUP_WAIT - 1)) begin
            state <= S_IDLE;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        S_IDLE: begin
          if (!hardware_store_busy_n_i) begin
            state <= S_HOLD;
          end else if (cmd_valid_i) begin
            is_write <= (cmd_op_i == CMD_WRITE);
            is_seq <= cmd_op_i[1];
            seq_store <= (cmd_op_i == CMD_STORE);
            seq_idx <= 3'd0;
            cnt <= '0;
            state <= S_ACC;
          end
        end
        S_ACC: begin
          if (cnt == CNT_W'(ACCESS_CYC - 1)) begin
            cnt <= '0;
            state <= S_GAP;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        S_GAP: begin
          cnt <= '0;
          if (is_seq && seq_idx != 3'(SEQ_LEN - 1)) begin
            seq_idx <= seq_idx + 3'd1;
            state <= S_ACC;
          end else if (is_seq) begin
            state <= S_WAIT;
          end else begin
            state <= S_IDLE;
          end
        end
        S_WAIT: begin
          if (cnt == CNT_W'((seq_store ? STORE_WAIT : RECALL_WAIT) - 1)) begin
            cnt <= '0;
            state <= S_IDLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        S_HOLD: begin
          if (hardware_store_busy_n_i) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // pin drive: address held over whole access and gap
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr_o <= '0;
      data_lines_o <= '0;
    end else if (state == S_IDLE && cmd_valid_i && hardware_store_busy_n_i) begin
      mem_addr_o <= cmd_op_i[1] ? {1'b0, SEQ_A1} : cmd_addr_i;
      data_lines_o <= cmd_wdata_i;
    end else if (state == S_GAP && is_seq && seq_idx != 3'(SEQ_LEN - 1)) begin
      mem_addr_o <= {1'b0, seq_addr(seq_idx + 3'd1, seq_store)};
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      chip_on_low_n_o <= 1'b1;
      output_on_low_n_o <= 1'b1;
      data_load_n_o <= 1'b1;
      data_lines_oe_n_o <= 1'b1;
    end else begin
      chip_on_low_n_o <= !(next_acc);
      output_on_low_n_o <= !(next_acc && !next_wr && !next_seq);
      data_load_n_o <= !(next_acc && next_wr);
      data_lines_oe_n_o <= !(next_acc && next_wr);
    end
  end

  always_comb begin
    next_acc = 1'b0;
    next_wr = is_write;
    next_seq = is_seq;
    if (state == S_IDLE && cmd_valid_i && hardware_store_busy_n_i) begin
      next_acc = 1'b1;
      next_wr = (cmd_op_i == CMD_WRITE);
      next_seq = cmd_op_i[1];
    end else if (state == S_ACC && cnt != CNT_W'(ACCESS_CYC - 1)) begin
      next_acc = 1'b1;
    end else if (state == S_GAP && is_seq && seq_idx != 3'(SEQ_LEN - 1)) begin
      next_acc = 1'b1;
    end
  end

  // read data sampled in last access cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= (state == S_ACC) && (cnt == CNT_W'(ACCESS_CYC - 1)) && !is_seq;
      if (state == S_ACC && cnt == CNT_W'(ACCESS_CYC - 1) && !is_write && !is_seq) begin
        rsp_rdata_o <= data_lines_i;
      end
    end
  end

  property p_write_oe;
    @(posedge mclk_i) disable iff (rst_i) !data_load_n_o |-> output_on_low_n_o;
  endproperty
  a_write_oe: assert property (p_write_oe) else $error("output enable low in write");

  property p_write_sel;
    @(posedge mclk_i) disable iff (rst_i)
      !data_load_n_o |-> !chip_on_low_n_o && !data_lines_oe_n_o;
  endproperty
  a_write_sel: assert property (p_write_sel) else $error("write without chip enable");

  property p_addr_stable;
    @(posedge mclk_i) disable iff (rst_i)
      !chip_on_low_n_o && !$past(chip_on_low_n_o) |-> $stable(mem_addr_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in access");

  property p_boot_quiet;
    @(posedge mclk_i) disable iff (rst_i) state == S_BOOT |-> chip_on_low_n_o && !cmd_ready_o;
  endproperty
  a_boot_quiet: assert property (p_boot_quiet) else $error("access during boot");

  property p_wait_quiet;
    @(posedge mclk_i) disable iff (rst_i) state == S_WAIT |=> chip_on_low_n_o;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("access during nv wait");

  sequence s_seq_end;
    state == S_GAP && is_seq && seq_idx == 3'(SEQ_LEN - 1);
  endsequence
  property p_seq_wait;
    @(posedge mclk_i) disable iff (rst_i) s_seq_end |=> state == S_WAIT;
  endproperty
  a_seq_wait: assert property (p_seq_wait) else $error("no wait after sequence");

  property p_seq_no_oe;
    @(posedge mclk_i) disable iff (rst_i)
      is_seq && !chip_on_low_n_o |-> output_on_low_n_o && data_load_n_o;
  endproperty
  a_seq_no_oe: assert property (p_seq_no_oe) else $error("sequence not a plain read");

  property p_seq_hi_bit;
    @(posedge mclk_i) disable iff (rst_i) is_seq && !chip_on_low_n_o |-> !mem_addr_o[SEQ_CMP_W];
  endproperty
  a_seq_hi_bit: assert property (p_seq_hi_bit) else $error("sequence top bit set");

  property p_busy_hold;
    @(posedge mclk_i) disable iff (rst_i)
      !hardware_store_busy_n_i && state == S_IDLE |=> nv_busy_o && chip_on_low_n_o;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy pin low not held");
endmodule // nvsram_host_ctl
`default_nettype wire

// file: tb/nvsram_dev_model.sv
// behavioural nonvolatile-shadowed 32k x 8 memory facing the host controller
// assumes the bench resolves the shared data and busy wires from both parties
`timescale 1ns/1ps
`default_nettype none
module nvsram_dev_model #(
  parameter int ACC_NS = 20,
  parameter int NV_NS = 60,
  parameter int PWR_NS = 90
) (
  // memory pins
  input wire logic [14:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] dq_i,
  input wire logic busy_n_i,
  // device drive
  output logic [7:0] dq_o,
  output logic dq_on_o,
  output logic busy_pull_n_o
);
  localparam logic [13:0] SEQ [5] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
  logic [7:0] sram [0:32767];
  logic [7:0] nv [0:32767];
  logic [7:0] last = 8'h00;
  logic [7:0] dq_d;
  logic [14:0] addr_d;
  logic active = 1'b1;
  logic wr_d, rd_d;
  int step = 0;
  wire logic rd = !ce_n_i && !oe_n_i && we_n_i && busy_n_i && !active;
  // values from just before an edge, since the host changes pins on that same edge
  assign #0.1 dq_d = dq_i;
  assign #0.1 addr_d = addr_i;
  assign #0.1 wr_d = !ce_n_i && !we_n_i && busy_n_i && !active;
  assign #0.1 rd_d = !ce_n_i && we_n_i && busy_n_i && !active;
  task automatic nv_op(input bit store, input int dur);
    active = 1'b1;
    busy_pull_n_o = !store;
    for (int i = 0; i < 32768; i++) begin
      if (store) nv[i] = 8'hff;
      else sram[i] = 8'h00;
    end
    #(dur);
    for (int i = 0; i < 32768; i++) begin
      if (store) nv[i] = sram[i];
      else sram[i] = nv[i];
    end
    busy_pull_n_o = 1'b1;
    active = 1'b0;
  endtask
  initial begin
    busy_pull_n_o = 1'b1;
    for (int i = 0; i < 32768; i++) nv[i] = 8'(i) ^ 8'ha5;
    nv_op(1'b0, PWR_NS);
  end
  // released lines show the inverse of the last value
  always @(addr_i or rd) begin
    dq_on_o = 1'b0;
    dq_o = ~last;
    if (rd) begin
      #(ACC_NS);
      if (rd) begin
        last = sram[addr_i];
        dq_o = last;
        dq_on_o = 1'b1;
      end
    end
  end
  always @(posedge ce_n_i or posedge we_n_i) begin
    if (wr_d) begin
      sram[addr_d] = dq_d;
      step = 0;
    end else if (rd_d && ce_n_i) begin
      if (step == 5 && addr_d[13:0] inside {14'h0fc0, 14'h0c63}) begin
        step = 0;
        nv_op(addr_d[13:0] == 14'h0fc0, NV_NS);
      end else if (step < 5 && addr_d[13:0] == SEQ[step]) step++;
      else step = (addr_d[13:0] == SEQ[0]) ? 1 : 0;
    end
  end
endmodule // nvsram_dev_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench: host controller against the behavioural memory model
// assumes the package and model are compiled first; long waits shortened by parameters
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvsram_ctl_pkg::*;
  localparam int WAITS = 20;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_op_i = CMD_READ;
  logic [14:0] cmd_addr_i = '0;
  logic [7:0] cmd_wdata_i = '0;
  logic tb_pull_n = 1'b1;
  logic cmd_ready_o, rsp_valid_o, ce_n, oe_n, we_n, dq_oe_n, busy_o, busy_oe_n, nv_busy_o;
  logic dev_on, dev_pull_n;
  logic [7:0] rsp_rdata_o, dq_host, dq_dev;
  logic [14:0] mem_addr;
  wire logic [7:0] dq_bus = !dq_oe_n ? dq_host : dq_dev;
  wire logic busy_pin = dev_pull_n & tb_pull_n & (busy_oe_n | busy_o);
  int fails = 0;
  int tests_run = 0;
  always #2 mclk_i = ~mclk_i;
  nvsram_host_ctl #(.STORE_WAIT(WAITS), .RECALL_WAIT(WAITS), .POWERUP_WAIT(WAITS)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(mem_addr),
    .chip_on_low_n_o(ce_n), .output_on_low_n_o(oe_n), .data_load_n_o(we_n),
    .data_lines_i(dq_bus), .data_lines_o(dq_host), .data_lines_oe_n_o(dq_oe_n),
    .hardware_store_busy_n_i(busy_pin), .hardware_store_busy_n_o(busy_o),
    .hardware_store_busy_oe_n_o(busy_oe_n), .nv_busy_o(nv_busy_o));
  nvsram_dev_model MEM (.addr_i(mem_addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .dq_i(dq_bus), .busy_n_i(busy_pin), .dq_o(dq_dev), .dq_on_o(dev_on),
    .busy_pull_n_o(dev_pull_n));
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_for(input int bound, output int n);
    n = 0;
    while (cmd_ready_o !== 1'b1) begin
      @(negedge mclk_i);
      n++;
      if (n > bound) begin
        check_flag("ready", 1'b1, cmd_ready_o);
        tally_and_finish();
      end
    end
  endtask
  // one command through the user port, entered and left at a falling edge
  task automatic do_cmd(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d,
                        output logic [7:0] q, output int n);
    int k;
    wait_for(400, k);
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_wdata_i = d;
    cmd_valid_i = 1'b1;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    k = 0;
    while (op < CMD_STORE && rsp_valid_o !== 1'b1) begin
      @(negedge mclk_i);
      k++;
      if (k > 40) begin
        check_flag("response", 1'b1, rsp_valid_o);
        tally_and_finish();
      end
    end
    q = rsp_rdata_o;
    wait_for(400, n);
  endtask
  always @(negedge mclk_i) begin
    if (!dq_oe_n && dev_on) check_flag("bus clash", 1'b0, 1'b1);
    if (!we_n && !oe_n) check_flag("output enable in write", 1'b1, oe_n);
  end
  task automatic t_boot();
    logic [7:0] q;
    int n;
    @(negedge mclk_i);
    check_flag("ready in boot", 1'b0, cmd_ready_o);
    check_flag("nv busy in boot", 1'b1, nv_busy_o);
    do_cmd(CMD_READ, 15'h0123, 8'h00, q, n);
    check_byte("recalled byte", 8'h23 ^ 8'ha5, q);
  endtask
  task automatic t_rw();
    logic [14:0] addrs [5] = '{15'h0000, 15'h7fff, 15'h3fff, 15'h4000, 15'h0e38};
    logic [7:0] q;
    int n;
    foreach (addrs[i]) do_cmd(CMD_WRITE, addrs[i], 8'h11 * 8'(i) + 8'h0f, q, n);
    foreach (addrs[i]) begin
      do_cmd(CMD_READ, addrs[i], 8'h00, q, n);
      check_byte("read back", 8'h11 * 8'(i) + 8'h0f, q);
    end
  endtask
  task automatic t_store_recall();
    logic [7:0] q;
    int n;
    do_cmd(CMD_WRITE, 15'h0100, 8'h5a, q, n);
    do_cmd(CMD_STORE, 15'h0000, 8'h00, q, n);
    check_flag("store wait", 1'b1, n == 6 * (ACCESS_CYC + 1) + WAITS);
    do_cmd(CMD_WRITE, 15'h0100, 8'hc3, q, n);
    do_cmd(CMD_READ, 15'h0100, 8'h00, q, n);
    check_byte("before recall", 8'hc3, q);
    do_cmd(CMD_RECALL, 15'h0000, 8'h00, q, n);
    check_flag("recall wait", 1'b1, n == 6 * (ACCESS_CYC + 1) + WAITS);
    do_cmd(CMD_READ, 15'h0100, 8'h00, q, n);
    check_byte("stored byte", 8'h5a, q);
    do_cmd(CMD_RECALL, 15'h0000, 8'h00, q, n);
    do_cmd(CMD_READ, 15'h7fff, 8'h00, q, n);
    check_byte("second recall", 8'h20, q);
  endtask
  task automatic t_busy_pin();
    logic [7:0] q;
    int n;
    tb_pull_n = 1'b0;
    repeat (3) @(negedge mclk_i);
    check_flag("nv busy with pin low", 1'b1, nv_busy_o);
    repeat (8) @(negedge mclk_i);
    check_flag("ready with pin low", 1'b0, cmd_ready_o);
    check_flag("busy pin drive", 1'b1, busy_oe_n);
    tb_pull_n = 1'b1;
    do_cmd(CMD_READ, 15'h0100, 8'h00, q, n);
    check_byte("after pin release", 8'h5a, q);
  endtask
  initial begin
    repeat (4) @(negedge mclk_i);
    rst_i = 1'b0;
    t_boot();
    t_rw();
    t_store_recall();
    t_busy_pin();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
